/* src/see_pkg.sv */
/*
 * Constants, command encodings, states and carriers for the serial
 * EEPROM slave. Assumes a core clock of 125 MHz and a link clock that
 * the host drives and may stop between frames.
 */
package see_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int          WORDS       = 128;
    localparam int          WIDX_W      = 7;
    localparam int          DATA_W      = 16;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // frame field lengths
    // ------------------------------------------------------------
    localparam logic [4:0] OPC_BITS    = 5'h02;
    localparam logic [4:0] ADDR_BITS_W = 5'h08;
    localparam logic [4:0] ADDR_BITS_B = 5'h09;
    localparam logic [4:0] DATA_BITS_W = 5'h10;
    localparam logic [4:0] DATA_BITS_B = 5'h08;

    // ------------------------------------------------------------
    // opcodes and the sub-codes carried in the top address bits
    // ------------------------------------------------------------
    localparam logic [1:0] OP_SUB   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DIS  = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
    localparam logic [1:0] SUB_EN   = 2'h3;

    // ------------------------------------------------------------
    // programming time
    // ------------------------------------------------------------
    localparam int PROG_TIME_MS   = 10;
    localparam int CORE_CLK_KHZ   = 125000;
    localparam int PROG_CYCLES_DF = PROG_TIME_MS * CORE_CLK_KHZ;
    localparam int TMR_W          = 21;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PK_WRITE = 2'b00,
        PK_ERASE = 2'b01,
        PK_ERASE_ALL_CMD  = 2'b10,
        PK_WRITE_ALL_CMD  = 2'b11
    } see_prog_t;

    typedef struct packed {
        see_prog_t   kind;
        logic        byte_mode;
        logic [8:0]  addr;
        logic [15:0] data;
    } see_cmd_t;

    typedef enum logic [2:0] {
        L_START = 3'b000,
        L_OPC   = 3'b001,
        L_ADDR  = 3'b010,
        L_DATA  = 3'b011,
        L_READ  = 3'b100,
        L_DONE  = 3'b101
    } see_lst_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_ARM  = 2'b01,
        C_PROG = 2'b10
    } see_cst_t;

endpackage : see_pkg

/* src/see_sync.sv */
/*
 * Two-flop level synchroniser with asynchronous clear.
 * Assumes the input is a level that holds for several destination edges.
 */
`timescale 1ns/1ps
`default_nettype none

module see_sync (
    // clock and reset
    input  wire  logic clk,
    input  wire  logic rst_n,
    // level
    input  wire  logic d,
    output var   logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : see_sync
`default_nettype wire

/* src/see_eeprom.sv */
/*
 * Serial EEPROM slave: frame decoder on the serial clock, self-timed
 * programming engine and flip-flop array on the core clock.
 * Assumes the host keeps frame timing (select set up before the first
 * clock, data stable around rising edges) and gives two serial clock
 * edges with select low after power-on reset and after each
 * programming cycle before its next frame.
 */
// Function
// RULE1: array is 256 bytes or 128 words, chosen by width select
// RULE2: read, write, erase, erase all, write all instructions supported
// RULE3: read loads address into pointer and shifts that location out
// RULE4: pointer advances after each location; streaming continues while selected
// RULE5: pointer wraps from highest address to zero
// RULE6: programming is timed on the core clock, independent of serial clock
// RULE7: single write erases the location before programming it
// RULE8: single write programs exactly one byte or one word
// RULE9: ready or busy shown on data output whenever selected after programming starts
// RULE10: after select rises, zeros ignored; first one is the start bit
// RULE11: host sends two-bit opcode then 8 or 9 address bits
// RULE12: read emits one dummy zero then data msb first, dummy only once
// RULE13: programming starts when select falls; output zero busy, one ready
// RULE14: writes and erases rejected until enabled, until disabled again
// RULE15: width select high gives 16-bit words, low gives bytes
`timescale 1ns/1ps
`default_nettype none

module see_eeprom #(
    parameter int PROG_CYCLES = see_pkg::PROG_CYCLES_DF
) (
    // core clock and power-on reset
    input  wire  logic core_clk,
    input  wire  logic nrst,
    // serial link
    input  wire  logic sclk,
    input  wire  logic cs_i,
    input  wire  logic din_i,
    output logic       dout_o,
    output logic       dout_oe_n_o,
    // organisation select
    input  wire  logic org_i
);
    import see_pkg::*;

    // ------------------------------------------------------------
    // resets and crossings
    // ------------------------------------------------------------
    logic       crst_n;
    logic       lrst_n;
    logic       frame_rst_n;
    logic       cs_s;
    logic       req_s;
    logic       ack_l;
    logic       org_l;
    logic       req_q;
    logic       req_d;
    logic       ack_q;
    logic       ack_d;

    see_sync u_crst (.clk(core_clk), .rst_n(nrst),   .d(1'b1),  .q(crst_n));
    see_sync u_lrst (.clk(sclk),     .rst_n(nrst),   .d(1'b1),  .q(lrst_n));
    see_sync u_cs   (.clk(core_clk), .rst_n(crst_n), .d(cs_i),  .q(cs_s));
    see_sync u_req  (.clk(core_clk), .rst_n(crst_n), .d(req_q), .q(req_s));
    see_sync u_ack  (.clk(sclk),     .rst_n(lrst_n), .d(ack_q), .q(ack_l));
    see_sync u_org  (.clk(sclk),     .rst_n(lrst_n), .d(org_i), .q(org_l));

    // frame state dies with select; no clock edge is needed for that
    assign frame_rst_n = lrst_n & cs_i;

    // ------------------------------------------------------------
    // link side state
    // ------------------------------------------------------------
    see_lst_t    lst_q, lst_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [1:0]  opc_q, opc_d;
    logic [8:0]  addr_q, addr_d;
    logic [15:0] sh_q, sh_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        rd_on_q, rd_on_d;
    logic        rd_bit_q, rd_bit_d;
    logic        pe_q, pe_d;
    logic        stat_q, stat_d;
    see_cmd_t    cmd_q, cmd_d;
    logic [15:0] mem_q [WORDS];
    logic        rdy_q;

    logic        byte_mode;
    logic        lbusy;
    logic [4:0]  abits;
    logic [4:0]  dbits;

    assign byte_mode = ~org_l; // RULE15 RULE1
    assign abits     = byte_mode ? ADDR_BITS_B : ADDR_BITS_W;
    assign dbits     = byte_mode ? DATA_BITS_B : DATA_BITS_W;
    assign lbusy     = req_q ^ ack_l;

    // location at pointer, left-aligned so the msb always leaves from bit 15
    function automatic logic [15:0] see_fetch(input logic [15:0] w,
                                              input logic        lo_hi,
                                              input logic        bm);
        if (bm) begin
            see_fetch = lo_hi ? {w[15:8], 8'h00} : {w[7:0], 8'h00};
        end else begin
            see_fetch = w;
        end
    endfunction : see_fetch

    always_comb begin
        logic [8:0]  a_full;
        logic [1:0]  sub;
        logic        fire;
        see_prog_t   f_kind;
        logic [8:0]  f_addr;
        logic [15:0] f_data;
        logic [7:0]  p_nx;
        a_full   = {addr_q[7:0], din_i};
        sub      = byte_mode ? a_full[8:7] : a_full[7:6];
        fire     = 1'b0;
        f_kind   = PK_WRITE;
        f_addr   = addr_q;
        f_data   = {sh_q[14:0], din_i};
        p_nx     = byte_mode ? 8'(ptr_q + 8'h01) : {1'b0, 7'(ptr_q[6:0] + 7'h01)}; // RULE5
        lst_d    = lst_q;
        cnt_d    = cnt_q;
        opc_d    = opc_q;
        addr_d   = addr_q;
        sh_d     = sh_q;
        ptr_d    = ptr_q;
        rd_on_d  = rd_on_q;
        rd_bit_d = rd_bit_q;
        pe_d     = pe_q;
        stat_d   = stat_q;
        req_d    = req_q;
        cmd_d    = cmd_q;
        case (lst_q)
            L_START: begin
                // busy device ignores start bits, so no frame begins
                if (din_i && !lbusy) begin // RULE10
                    lst_d  = L_OPC;
                    cnt_d  = 5'h00;
                    stat_d = 1'b0;
                end
            end
            L_OPC: begin
                opc_d = {opc_q[0], din_i};
                cnt_d = 5'(cnt_q + 5'h01);
                if (cnt_q == OPC_BITS - 5'h01) begin // RULE11
                    lst_d = L_ADDR;
                    cnt_d = 5'h00;
                end
            end
            L_ADDR: begin
                addr_d = a_full;
                cnt_d  = 5'(cnt_q + 5'h01);
                if (cnt_q == abits - 5'h01) begin // RULE11
                    cnt_d = 5'h00;
                    lst_d = L_DONE;
                    case (opc_q)
                        OP_READ: begin // RULE3 RULE12
                            ptr_d    = a_full[7:0];
                            sh_d     = see_fetch(mem_q[byte_mode ? a_full[7:1] : a_full[6:0]],
                                                 a_full[0], byte_mode);
                            rd_on_d  = 1'b1;
                            rd_bit_d = 1'b0;
                            lst_d    = L_READ;
                        end
                        OP_WRITE: begin
                            lst_d = L_DATA;
                        end
                        OP_ERASE: begin
                            fire   = 1'b1;
                            f_kind = PK_ERASE;
                            f_addr = a_full;
                        end
                        default: begin
                            case (sub)
                                SUB_EN:   pe_d  = 1'b1; // RULE14
                                SUB_DIS:  pe_d  = 1'b0; // RULE14
                                SUB_WRITE_ALL_CMD: lst_d = L_DATA;
                                default: begin
                                    fire   = 1'b1;
                                    f_kind = PK_ERASE_ALL_CMD;
                                end
                            endcase
                        end
                    endcase
                end
            end
            L_DATA: begin
                sh_d  = {sh_q[14:0], din_i};
                cnt_d = 5'(cnt_q + 5'h01);
                if (cnt_q == dbits - 5'h01) begin // RULE8
                    fire   = 1'b1;
                    f_kind = (opc_q == OP_WRITE) ? PK_WRITE : PK_WRITE_ALL_CMD;
                    f_data = byte_mode ? {8'h00, sh_q[6:0], din_i} : {sh_q[14:0], din_i};
                    lst_d  = L_DONE;
                end
            end
            L_READ: begin
                rd_bit_d = sh_q[15]; // RULE12
                if (cnt_q == dbits - 5'h01) begin // RULE4
                    cnt_d = 5'h00;
                    ptr_d = p_nx;
                    sh_d  = see_fetch(mem_q[byte_mode ? p_nx[7:1] : p_nx[6:0]],
                                      p_nx[0], byte_mode);
                end else begin
                    cnt_d = 5'(cnt_q + 5'h01);
                    sh_d  = {sh_q[14:0], 1'b0};
                end
            end
            L_DONE: begin
                lst_d = L_DONE;
            end
            default: begin
                lst_d = L_START;
            end
        endcase
        // a command is handed over only while enabled
        if (fire && pe_q) begin // RULE14 RULE2
            req_d  = ~req_q;
            cmd_d  = '{kind: f_kind, byte_mode: byte_mode, addr: f_addr, data: f_data};
            stat_d = 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            lst_q    <= L_START;
            cnt_q    <= 5'h00;
            opc_q    <= 2'h0;
            addr_q   <= 9'h000;
            sh_q     <= 16'h0000;
            ptr_q    <= 8'h00;
            rd_on_q  <= 1'b0;
            rd_bit_q <= 1'b0;
        end else begin
            lst_q    <= lst_d;
            cnt_q    <= cnt_d;
            opc_q    <= opc_d;
            addr_q   <= addr_d;
            sh_q     <= sh_d;
            ptr_q    <= ptr_d;
            rd_on_q  <= rd_on_d;
            rd_bit_q <= rd_bit_d;
        end
    end

    // survives select; the only asynchronous clear is power-on reset
    always_ff @(posedge sclk or negedge lrst_n) begin
        if (!lrst_n) begin
            pe_q   <= 1'b0;
            stat_q <= 1'b0;
            req_q  <= 1'b0;
            cmd_q  <= '0;
        end else begin
            pe_q   <= pe_d;
            stat_q <= stat_d;
            req_q  <= req_d;
            cmd_q  <= cmd_d;
        end
    end

    // ------------------------------------------------------------
    // data output
    // ------------------------------------------------------------
    assign dout_o      = rd_on_q ? rd_bit_q : rdy_q; // RULE9 RULE13
    assign dout_oe_n_o = ~(cs_i & (rd_on_q | stat_q)); // RULE9

    // ------------------------------------------------------------
    // programming engine
    // ------------------------------------------------------------
    see_cst_t         cst_q, cst_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    see_cmd_t         ccmd_q, ccmd_d;
    logic             rdy_d;
    logic             commit;
    logic [15:0]      mem_d [WORDS];
    logic [6:0]       widx;
    logic [15:0]      tgt_val;
    logic [15:0]      write_all_cmd_val;
    logic [7:0]       new_byte;

    always_comb begin
        cst_d  = cst_q;
        tmr_d  = tmr_q;
        ccmd_d = ccmd_q;
        ack_d  = ack_q;
        commit = 1'b0;
        case (cst_q)
            C_IDLE: begin
                // link holds its command still until the ack returns
                if (req_s != ack_q) begin
                    ccmd_d = cmd_q;
                    cst_d  = C_ARM;
                end
            end
            C_ARM: begin
                if (!cs_s) begin // RULE13
                    tmr_d = '0;
                    cst_d = C_PROG;
                end
            end
            C_PROG: begin
                tmr_d = TMR_W'(tmr_q + 1'b1); // RULE6
                if (tmr_q == TMR_W'(PROG_CYCLES - 1)) begin // RULE6
                    commit = 1'b1;
                    ack_d  = ~ack_q;
                    cst_d  = C_IDLE;
                end
            end
            default: begin
                cst_d = C_IDLE;
            end
        endcase
        rdy_d = (cst_d == C_IDLE) && (req_s == ack_d); // RULE13
    end

    always_ff @(posedge core_clk or negedge crst_n) begin
        if (!crst_n) begin
            cst_q  <= C_IDLE;
            tmr_q  <= '0;
            ccmd_q <= '0;
            ack_q  <= 1'b0;
            rdy_q  <= 1'b1;
        end else begin
            cst_q  <= cst_d;
            tmr_q  <= tmr_d;
            ccmd_q <= ccmd_d;
            ack_q  <= ack_d;
            rdy_q  <= rdy_d;
        end
    end

    // ------------------------------------------------------------
    // array update
    // ------------------------------------------------------------
    // write lands as erase-then-program, so the cell simply takes the data
    assign widx     = ccmd_q.byte_mode ? ccmd_q.addr[7:1] : ccmd_q.addr[6:0];
    assign new_byte = (ccmd_q.kind == PK_ERASE) ? ERASED_BYTE : ccmd_q.data[7:0]; // RULE7
    assign tgt_val  = !ccmd_q.byte_mode ?
                      ((ccmd_q.kind == PK_ERASE) ? ERASED_WORD : ccmd_q.data) :
                      (ccmd_q.addr[0] ? {new_byte, mem_q[widx][7:0]}
                                      : {mem_q[widx][15:8], new_byte}); // RULE8
    // no erase in write all: programming only clears bits
    assign write_all_cmd_val = ccmd_q.byte_mode ? {ccmd_q.data[7:0], ccmd_q.data[7:0]} : ccmd_q.data;

    for (genvar i = 0; i < WORDS; i++) begin : g_cell
        always_comb begin
            mem_d[i] = mem_q[i];
            if (commit) begin // RULE2
                case (ccmd_q.kind)
                    PK_ERASE_ALL_CMD: mem_d[i] = ERASED_WORD;
                    PK_WRITE_ALL_CMD: mem_d[i] = mem_q[i] & write_all_cmd_val;
                    default: begin
                        if (widx == 7'(i)) begin
                            mem_d[i] = tgt_val;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge core_clk or negedge crst_n) begin
            if (!crst_n) begin
                mem_q[i] <= ERASED_WORD;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

endmodule : see_eeprom
`default_nettype wire

/* tb/see_eeprom_sva.sv */
/* Checker for see_eeprom: link frame decode and busy/ready timing.
   Assumes org_i is steady within frames and sclk stands still while polling. */
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_sva #(
    parameter int PROG_CYCLES = 20
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sclk,
    // link pins
    input wire logic cs_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire logic dout_oe_n_o,
    input wire logic org_i
);
    import see_pkg::*;
    localparam int RUN_LO = PROG_CYCLES - 8;
    localparam int RUN_HI = PROG_CYCLES + 8;
    logic       act_q;
    logic [4:0] cnt_q;
    logic [1:0] opc_q;
    logic [4:0] alen;
    logic       busy;
    logic       rd_hdr;
    int         run_q;
    wire        clr_n = nrst & cs_i;
    // ------------------------------------------------------------
    // frame tracker, bits counted after the start bit
    // ------------------------------------------------------------
    assign alen   = org_i ? 5'h08 : 5'h09;
    assign busy   = ~dout_oe_n_o & ~dout_o & ~act_q;
    assign rd_hdr = cs_i & act_q & (opc_q == OP_READ);
    always_ff @(posedge sclk or negedge clr_n) begin
        if (!clr_n) begin
            act_q <= 1'b0;
            cnt_q <= 5'h00;
            opc_q <= 2'h0;
        end else if (!act_q) begin
            act_q <= din_i & ~busy;
        end else begin
            cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
            opc_q <= (cnt_q < 5'h02) ? {opc_q[0], din_i} : opc_q;
        end
    end
    // busy run length, only meaningful while select stays high
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 0;
        end else begin
            run_q <= (cs_i && busy) ? run_q + 1 : 0;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    oe_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !cs_i |-> dout_oe_n_o) else $error("data out driven while deselected");
    rd_dummy_a: assert property (@(posedge sclk) disable iff (!nrst)
        (rd_hdr && cnt_q == alen + 5'h02) |-> (!dout_oe_n_o && !dout_o))
        else $error("no dummy zero after read address");
    rd_stream_a: assert property (@(posedge sclk) disable iff (!nrst)
        (rd_hdr && cnt_q > alen + 5'h02) |-> !dout_oe_n_o) else $error("read stream stopped");
    hdr_quiet_a: assert property (@(posedge sclk) disable iff (!nrst)
        (cs_i && act_q && cnt_q <= alen + 5'h01) |-> dout_oe_n_o)
        else $error("output driven during header");
    wr_quiet_a: assert property (@(posedge sclk) disable iff (!nrst)
        (cs_i && act_q && opc_q == OP_WRITE && cnt_q == alen + 5'h02) |-> dout_oe_n_o)
        else $error("write frame drove data out");
    busy_max_a: assert property (@(posedge core_clk) disable iff (!nrst)
        busy |-> run_q < RUN_HI) else $error("busy too long");
    busy_min_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ($fell(busy) && cs_i && !dout_oe_n_o) |-> run_q >= RUN_LO) else $error("ready too early");
    rdy_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ($fell(busy) && cs_i && !dout_oe_n_o) |=> (!cs_i || (!dout_oe_n_o && dout_o)) [*4])
        else $error("ready not held");
    rd_c: cover property (@(posedge sclk) disable iff (!nrst) rd_hdr && cnt_q == alen + 5'h02);
    wr_c: cover property (@(posedge sclk) disable iff (!nrst) act_q && opc_q == OP_WRITE);
    rdy_c: cover property (@(posedge core_clk) disable iff (!nrst) $fell(busy) && cs_i);
endmodule : see_eeprom_sva
bind see_eeprom see_eeprom_sva #(.PROG_CYCLES(PROG_CYCLES)) i_sva (
    .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_i(cs_i), .din_i(din_i),
    .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .org_i(org_i));
`default_nettype wire

/* tb/see_host.sv */
/* Host model on the serial link: frames, reads and ready polls.
   Assumes the bench gives the data line already resolved from the enable. */
`timescale 1ns/1ps
`default_nettype none
module see_host (
    // link pins
    output var logic        sclk,
    output var logic        cs,
    output var logic        din,
    input  wire logic       line,
    // results
    output var logic [63:0] res,
    output var logic        res_stb
);
    initial begin
        sclk = 1'b0;
        cs = 1'b0;
        din = 1'b0;
        res = '0;
        res_stb = 1'b0;
    end
    // one link bit: data set while clock low, read back mid high phase
    task automatic edge1(input logic b, output logic q);
        din = b;
        #16 sclk = 1'b1;
        #8 q = line;
        #8 sclk = 1'b0;
    endtask : edge1
    task automatic idle(input int n);
        logic q;
        for (int i = 0; i < n; i++) edge1(1'b0, q);
    endtask : idle
    task automatic frame(input int nb, input logic [27:0] bits, input int nrd);
        logic q;
        #3.7 cs = 1'b1;
        for (int i = nb - 1; i >= 0; i--) edge1(bits[i], q);
        res = {63'h0, q};
        for (int i = 0; i < nrd; i++) begin
            edge1(1'b0, q);
            res = {res[62:0], q};
        end
        // deselect before the next rising clock edge
        cs = 1'b0;
        din = ~din;
        if (nrd > 0) res_stb = 1'b1;
        #64 res_stb = 1'b0;
    endtask : frame
    // select with the clock stopped, wait for ready, bounded
    task automatic poll();
        logic a;
        #3.7 cs = 1'b1;
        #16 a = line;
        for (int i = 0; i < 100 && line !== 1'b1; i++) #8;
        #40 res = {62'h0, a, line};
        cs = 1'b0;
        res_stb = 1'b1;
        #64 res_stb = 1'b0;
        // done handshake reaches the link side only on serial clock edges
        idle(2);
    endtask : poll
endmodule : see_host
`default_nettype wire

/* tb/serial_eeprom_2kbit_slave_tb.sv */
/* Self-checking bench for see_eeprom driven by the see_host model.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module serial_eeprom_2kbit_slave_tb;
    import see_pkg::*;
    typedef struct {
        string       nm;
        logic [63:0] v;
    } see_exp_t;
    logic        core_clk;
    logic        nrst;
    logic        org;
    logic        sclk;
    logic        cs;
    logic        din;
    logic        dout;
    logic        oe_n;
    logic        stb;
    logic [63:0] res;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] bv;
    wire         line;
    int          n_errors     = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    see_exp_t    exp_q[$];
    // no pull on the data line, so a released line reads z
    assign line = oe_n ? 1'bz : dout;
    see_eeprom #(.PROG_CYCLES(20)) i_dut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
        .cs_i(cs), .din_i(din), .dout_o(dout), .dout_oe_n_o(oe_n), .org_i(org));
    see_host i_host (.sclk(sclk), .cs(cs), .din(din), .line(line), .res(res), .res_stb(stb));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    always @(posedge stb) begin
        see_exp_t e;
        e = exp_q.pop_front();
        `CHK(e.nm, e.v, res)
    end
    // mode 1: expect busy then ready, mode 2: expect no status at all
    task automatic op(input logic [1:0] opc, input logic [8:0] a, input int nd,
                      input logic [15:0] d, input int nrd, input int mode);
        int          al;
        logic [27:0] bits;
        al = org ? 8 : 9;
        if (opc == OP_SUB) a = 9'(a << (al - 2));
        bits = (28'({1'b1, opc}) << (al + nd)) | (28'(a) << nd) | 28'(d);
        i_host.frame(4 + al + nd, bits, nrd);
        if (mode != 0) begin
            exp_q.push_back('{"poll", (mode == 1) ? 64'h1 : {62'h0, 2'bzz}});
            i_host.poll();
        end
    endtask : op
    task automatic rd(input string nm, input logic [8:0] a, input int nrd, input logic [63:0] v);
        exp_q.push_back('{nm, v});
        op(OP_READ, a, 0, 16'h0, nrd, 0);
        $display("test %s done", nm);
    endtask : rd
    initial begin
        nrst = 1'b0;
        org = 1'b1;
        void'($urandom(32'h6697));
        d1 = 16'($urandom);
        d2 = 16'($urandom);
        bv = 16'($urandom);
        repeat (16) @(posedge core_clk);
        #1 nrst = 1'b1;
        i_host.idle(4);
        rd("fresh", 9'h07F, 32, {31'h0, 1'b0, 16'hFFFF, 16'hFFFF});
        op(OP_WRITE, 9'h07F, 16, d1, 0, 2);
        rd("locked", 9'h07F, 16, {47'h0, 1'b0, 16'hFFFF});
        op(OP_SUB, 9'h003, 0, 16'h0, 0, 0);
        op(OP_WRITE, 9'h07F, 16, d1, 0, 1);
        op(OP_WRITE, 9'h07F, 16, d2, 0, 1);
        rd("word", 9'h07E, 48, {15'h0, 1'b0, 16'hFFFF, d2, 16'hFFFF});
        op(OP_ERASE, 9'h07F, 0, 16'h0, 0, 1);
        rd("erased", 9'h07F, 16, {47'h0, 1'b0, 16'hFFFF});
        op(OP_SUB, 9'h002, 0, 16'h0, 0, 1);
        op(OP_SUB, 9'h001, 16, d1, 0, 1);
        rd("all", 9'h000, 32, {31'h0, 1'b0, d1, d1});
        @(posedge core_clk);
        #1 org = 1'b0;
        i_host.idle(4);
        op(OP_WRITE, 9'h009, 8, {8'h00, bv[7:0]}, 0, 1);
        rd("bytes", 9'h008, 16, {47'h0, 1'b0, d1[7:0], bv[7:0]});
        rd("wrap8", 9'h0FF, 16, {47'h0, 1'b0, d1[15:8], d1[7:0]});
        op(OP_SUB, 9'h000, 0, 16'h0, 0, 0);
        op(OP_WRITE, 9'h008, 8, 16'h00AA, 0, 2);
        rd("x8lock", 9'h008, 8, {55'h0, 1'b0, d1[7:0]});
        close_out();
    end
endmodule : serial_eeprom_2kbit_slave_tb
`default_nettype wire
